// *** verification/i2c_master_model.sv ***
// two-wire bus master model driving open-drain pull-downs
// assumes pull-ups on both lines outside; times in ns
`timescale 1ns/1ps
module i2c_master_model #(
  parameter int Q = 625
) (
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_low_out,
  output logic      sda_low_out
);
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end

  // one clock; waits while the slave holds scl low
  task automatic clk_bit(input logic b, output logic s);
    #Q sda_low_out = !b;
    #Q scl_low_out = 1'b0;
    wait (scl_in);
    #Q s = sda_in;
    #Q scl_low_out = 1'b1;
  endtask

  // start (or repeated start) when first is 1, stop when 0
  task automatic cond(input logic first);
    #Q sda_low_out = !first;
    #Q scl_low_out = 1'b0;
    wait (scl_in);
    #Q sda_low_out = first;
    #Q scl_low_out = first;
  endtask

  // msb first, ninth clock returns the slave acknowledge
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, ack);
  endtask

  task automatic read_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(ack, s);
  endtask
endmodule

// *** verification/i2c_slave_ram_tb.sv ***
// self-checking bench: register port tasks plus a bus master model
// assumes the design's map header and package
`timescale 1ns/1ps
`include "i2c_slave_map.svh"
`define CHK(w, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s exp %h got %h", w, e, g); end end
module i2c_slave_ram_tb;
  import i2c_slave_pkg::*;
  logic       mclk_in = 1'b0;
  logic       reset_n_in = 1'b0;
  logic       reg_wr_in = 1'b0;
  logic       reg_rd_in = 1'b0;
  logic       gpio_scl_low_in = 1'b1;
  logic       gpio_sda_low_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out;
  logic [7:0] v;
  logic       irq_out, scl_out_out, scl_oe_out, sda_out_out, sda_oe_out;
  logic       m_scl_low, m_sda_low, ack;
  logic [7:0] wseq [5] = '{8'h84, 8'h1e, 8'h11, 8'h22, 8'h33};
  logic [7:0] rseq [4] = '{8'h77, 8'h11, 8'h22, 8'hff};
  int         fails = 0;
  int         checked = 0;
  int         cycles = 0;
  int         stalls = 0;
  bit         bufm = 1'b0;
  wire        scl_in = !(scl_oe_out | m_scl_low);
  wire        sda_in = !(sda_oe_out | m_sda_low);

  i2c_slave_ram i2c_slave_ram_inst (
    .mclk_in         (mclk_in),
    .reset_n_in      (reset_n_in),
    .reg_addr_in     (reg_addr_in),
    .reg_wdata_in    (reg_wdata_in),
    .reg_wr_in       (reg_wr_in),
    .reg_rd_in       (reg_rd_in),
    .reg_rdata_out   (reg_rdata_out),
    .irq_out         (irq_out),
    .scl_in          (scl_in),
    .scl_out_out     (scl_out_out),
    .scl_oe_out      (scl_oe_out),
    .sda_in          (sda_in),
    .sda_out_out     (sda_out_out),
    .sda_oe_out      (sda_oe_out),
    .gpio_scl_low_in (gpio_scl_low_in),
    .gpio_sda_low_in (gpio_sda_low_in)
  );

  i2c_master_model i2c_master_model_inst (
    .scl_in      (scl_in),
    .sda_in      (sda_in),
    .scl_low_out (m_scl_low),
    .sda_low_out (m_sda_low)
  );

  always #12.5 mclk_in = ~mclk_in;

  always @(posedge mclk_in) begin
    cycles++;
    if (bufm && scl_oe_out !== 1'b0) stalls++;
    if (cycles == 60000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string w);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
    `CHK(w, e, v)
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(posedge mclk_in);
      #1 n++;
    end while (irq_out !== 1'b1 && n < 5000);
    `CHK("irq", 1'b1, irq_out)
  endtask

  initial begin
    repeat (12) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    #1 `CHK("gpio scl", 1'b1, scl_oe_out)
    rdchk(`REG_CTRL, `CTRL_RESET, "ctrl");
    rdchk(8'h3f, 8'h00, "unmapped");
    for (int s = 0; s < 3; s++) begin
      wr(`REG_CTRL, {3'h0, s[1:0], 3'h0});
      rdchk(`REG_CTRL, {3'h0, s[1:0], 3'h0}, "speed");
    end
    @(posedge mclk_in);
    gpio_scl_low_in <= 1'b0;
    gpio_sda_low_in <= 1'b1;
    wr(`REG_OWN_ADDR, 8'h42);
    wr(`REG_MASK, 8'h06);
    wr(`REG_CTRL, 8'h01);
    repeat (4) @(posedge mclk_in);
    `CHK("gpio sda", 1'b0, sda_oe_out)
    `CHK("pad lows", 2'b00, {scl_out_out, sda_out_out})
    wr(`REG_STATUS, 8'hff);
    fork
      begin
        i2c_master_model_inst.cond(1'b1);
        i2c_master_model_inst.write_byte(8'h84, ack);
        `CHK("addr ack", 1'b0, ack)
        i2c_master_model_inst.write_byte(8'h5a, ack);
        `CHK("data ack", 1'b0, ack)
        i2c_master_model_inst.cond(1'b0);
      end
      begin
        wait_irq();
        rdchk(`REG_STATUS, 8'h03, "status addr");
        `CHK("stall addr", 1'b1, scl_oe_out)
        rdchk(`REG_RX_DATA, 8'h84, "rx addr");
        wr(`REG_STATUS, 8'h03);
        wait_irq();
        rdchk(`REG_STATUS, 8'h04, "status rx");
        wr(`REG_MASK, 8'h00);
        #1 `CHK("masked irq", 1'b0, irq_out)
        rdchk(`REG_RX_DATA, 8'h5a, "rx data");
      end
    join
    i2c_master_model_inst.cond(1'b1);
    i2c_master_model_inst.write_byte(8'h90, ack);
    `CHK("foreign ack", 1'b1, ack)
    i2c_master_model_inst.cond(1'b0);
    wr(`REG_STATUS, 8'hff);
    wr(`REG_MASK, 8'h28);
    fork
      begin
        i2c_master_model_inst.cond(1'b1);
        i2c_master_model_inst.write_byte(8'h85, ack);
        i2c_master_model_inst.read_byte(1'b1, v);
        `CHK("tx byte", 8'hc3, v)
        i2c_master_model_inst.cond(1'b0);
      end
      begin
        wait_irq();
        rdchk(`REG_STATUS, 8'h0b, "status tx");
        `CHK("stall tx", 1'b1, scl_oe_out)
        wr(`REG_TX_DATA, 8'hc3);
        wr(`REG_STATUS, 8'h0b);
        wait_irq();
        rdchk(`REG_STATUS, 8'h20, "status nack");
      end
    join
    wr(`REG_STATUS, 8'hff);
    wr(`REG_CTRL, 8'h13);
    wr(`REG_BUF_INDEX, 8'h1d);
    wr(`REG_BUF_DATA, 8'h77);
    bufm = 1'b1;
    i2c_master_model_inst.cond(1'b1);
    foreach (wseq[i]) begin
      i2c_master_model_inst.write_byte(wseq[i], ack);
      `CHK("buf ack", 1'b0, ack)
    end
    i2c_master_model_inst.cond(1'b1);
    i2c_master_model_inst.write_byte(8'h84, ack);
    i2c_master_model_inst.write_byte(8'h1d, ack);
    i2c_master_model_inst.cond(1'b1);
    i2c_master_model_inst.write_byte(8'h85, ack);
    foreach (rseq[i]) begin
      i2c_master_model_inst.read_byte(i == 3, v);
      `CHK("buf read", rseq[i], v)
    end
    i2c_master_model_inst.cond(1'b0);
    bufm = 1'b0;
    `CHK("no stall", 0, stalls)
    wr(`REG_BUF_INDEX, 8'h1f);
    rdchk(`REG_BUF_DATA, 8'h22, "ram 31");
    rdchk(`REG_BUS_STATE, 8'h60, "bus state");
    `CHK("ptr end", 6'h20, v[5:0])
    wr(`REG_CTRL, 8'h05);
    repeat (4) @(posedge mclk_in);
    i2c_master_model_inst.cond(1'b1);
    i2c_master_model_inst.write_byte(8'h84, ack);
    `CHK("monitor ack", 1'b1, ack)
    i2c_master_model_inst.cond(1'b0);
    wr(`REG_CTRL, 8'h43);
    i2c_master_model_inst.cond(1'b1);
    i2c_master_model_inst.write_byte(8'h90, ack);
    `CHK("any addr ack", 1'b0, ack)
    wr(`REG_CTRL, 8'h63);
    i2c_master_model_inst.write_byte(8'h00, ack);
    `CHK("nack data", 1'b1, ack)
    i2c_master_model_inst.cond(1'b0);
    report_and_stop();
  end
endmodule

// *** verilog/i2c_pin_sync.sv ***
// two-flop synchroniser with edge detection for one bus line
// assumes the pin is asynchronous to mclk_in
`timescale 1ns/1ps
module i2c_pin_sync (
  input  wire logic                mclk_in,
  input  wire logic                reset_n_in,
  input  wire logic                pin_in,
  output i2c_slave_pkg::pin_evt_t  evt_out
);
  import i2c_slave_pkg::*;

  logic [2:0] sh_q;
  logic [2:0] sh_d;

  always_comb begin
    sh_d = {sh_q[1:0], pin_in};
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      sh_q <= 3'h7;
    end else begin
      sh_q <= sh_d;
    end
  end

  // stage 0 feeds only stage 1; edges compare stages 1 and 2
  assign evt_out.lvl  = sh_q[1];
  assign evt_out.rise = sh_q[1] & ~sh_q[2];
  assign evt_out.fall = ~sh_q[1] & sh_q[2];
endmodule

// *** verilog/i2c_slave_map.svh ***
// register offsets, field positions, reset values and timing figures
// assumes an 8-bit register port and a 40 MHz system clock
`ifndef I2C_SLAVE_MAP_SVH
`define I2C_SLAVE_MAP_SVH

`define REG_CTRL       8'h00
`define REG_OWN_ADDR   8'h01
`define REG_STATUS     8'h02
`define REG_MASK       8'h03
`define REG_RX_DATA    8'h04
`define REG_TX_DATA    8'h05
`define REG_BUS_STATE  8'h06
`define REG_BUF_INDEX  8'h07
`define REG_BUF_DATA   8'h08

`define EV_START       0
`define EV_ADDR        1
`define EV_RX          2
`define EV_TX_REQ      3
`define EV_STOP        4
`define EV_NACK        5

`define CTRL_RESET     8'h00
`define ADDR_RESET     7'h00
`define SPEED_50K      2'h0
`define SPEED_100K     2'h1
`define SPEED_400K     2'h2

`define BUF_DEPTH      32
`define FILL_BYTE      8'hff

`define CLK_MHZ        40
`define HOLD_STD_NS    1000
`define HOLD_FAST_NS   300

`endif

// *** verilog/i2c_slave_pkg.sv ***
// shared types of the two-wire slave
// assumes nothing beyond a SystemVerilog compiler
package i2c_slave_pkg;

  typedef struct packed {
    logic       lvl;
    logic       rise;
    logic       fall;
  } pin_evt_t;

  typedef struct packed {
    logic       spare;
    logic       addr_all;
    logic       nack;
    logic [1:0] speed;
    logic       monitor;
    logic       buf_mode;
    logic       enable;
  } ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_RX,
    ST_TX,
    ST_MACK
  } fsm_state_t;

endpackage

// *** verilog/i2c_slave_ram.sv ***
// two-wire bus slave with stalling byte mode and a 32-byte no-stall buffer mode
// assumes open-drain pads outside, an 8-bit register port and a 40 MHz clock
// Operation
// - detect bus conditions, generate framing bits
// - slave only, transmit and receive
// - firmware exchanges whole bytes only
// - status polling or masked interrupt
// - works with bus clocks to 400 kHz
// - hardware 7-bit address compare
// - ten-bit and SMBus left to firmware
// - low-power bus monitoring mode
// - two dedicated pins, taken while enabled
// - all access through processor registers
// - default mode stalls until firmware services
// - buffered mode exposes 32-byte RAM
// - master sets buffer pointer by protocol
// - buffered mode never stalls the bus
// - bus speed selectable 50/100/400 kHz
// - no clock stretching in buffered mode
`timescale 1ns/1ps
`include "i2c_slave_map.svh"
module i2c_slave_ram (
  input  wire logic       mclk_in,
  input  wire logic       reset_n_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  output logic            irq_out,
  input  wire logic       scl_in,
  output logic            scl_out_out,
  output logic            scl_oe_out,
  input  wire logic       sda_in,
  output logic            sda_out_out,
  output logic            sda_oe_out,
  input  wire logic       gpio_scl_low_in,
  input  wire logic       gpio_sda_low_in
);
  import i2c_slave_pkg::*;

  localparam int HOLD_STD_CYC  = (`HOLD_STD_NS * `CLK_MHZ + 999) / 1000;
  localparam int HOLD_FAST_CYC = (`HOLD_FAST_NS * `CLK_MHZ + 999) / 1000;

  pin_evt_t   scl;
  pin_evt_t   sda;
  ctrl_t      ctrl_q, ctrl_d;
  logic [6:0] own_q, own_d;
  logic [5:0] status_q, status_d, mask_q, mask_d;
  logic [7:0] tx_q, tx_d, rdata_q, rdata_d;
  logic [4:0] fw_idx_q, fw_idx_d;
  fsm_state_t state_q, state_d;
  logic [7:0] shreg_q, shreg_d, rxbyte_q, rxbyte_d;
  logic [3:0] bitcnt_q, bitcnt_d;
  logic [5:0] ptr_q, ptr_d, hold_q, hold_d, hold_sel;
  logic       rw_q, rw_d, first_q, first_d, mnack_q, mnack_d;
  logic       stall_q, stall_d, rel_q, rel_d, drv_q, drv_d, pend_q, pend_d;
  logic [5:0] ev;
  logic       go_tx, start_c, stop_c, fw_rx_rd, fw_tx_wr, fw_ram_we, ram_we;
  logic [7:0] ram_rd;
  logic [7:0] ram [0:`BUF_DEPTH-1];

  i2c_pin_sync u_scl (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .pin_in     (scl_in),
    .evt_out    (scl)
  );

  i2c_pin_sync u_sda (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .pin_in     (sda_in),
    .evt_out    (sda)
  );

  // start and stop are sda edges while scl is high
  assign start_c  = sda.fall & scl.lvl;
  assign stop_c   = sda.rise & scl.lvl;
  assign fw_rx_rd = reg_rd_in && reg_addr_in == `REG_RX_DATA;
  assign fw_tx_wr = reg_wr_in && reg_addr_in == `REG_TX_DATA;
  assign fw_ram_we = reg_wr_in && reg_addr_in == `REG_BUF_DATA;
  assign ram_rd   = ptr_q < 6'(`BUF_DEPTH) ? ram[ptr_q[4:0]] : `FILL_BYTE;
  assign hold_sel = ctrl_q.speed == `SPEED_400K ? 6'(HOLD_FAST_CYC) : 6'(HOLD_STD_CYC);

  // protocol engine
  always_comb begin
    state_d  = state_q;
    shreg_d  = shreg_q;
    rxbyte_d = rxbyte_q;
    bitcnt_d = bitcnt_q;
    ptr_d    = ptr_q;
    rw_d     = rw_q;
    first_d  = first_q;
    mnack_d  = mnack_q;
    stall_d  = stall_q;
    rel_d    = rel_q;
    drv_d    = drv_q;
    pend_d   = pend_q;
    hold_d   = hold_q;
    ev       = 6'h00;
    go_tx    = 1'b0;
    ram_we   = 1'b0;
    // sda changes a hold time after scl falls
    if (hold_q != 6'h00) begin
      hold_d = hold_q - 6'h01;
      if (hold_q == 6'h01) begin
        drv_d = pend_q;
      end
    end
    if (stall_q && rel_q && hold_q == 6'h00) begin
      stall_d = 1'b0;
      rel_d   = 1'b0;
    end
    if (fw_rx_rd && stall_q && !rw_q) begin
      rel_d = 1'b1;
    end
    if (fw_tx_wr && stall_q && rw_q) begin
      shreg_d = reg_wdata_in;
      pend_d  = ~reg_wdata_in[7];
      hold_d  = hold_sel;
      rel_d   = 1'b1;
    end
    if (!ctrl_q.enable) begin
      state_d = ST_IDLE;
      stall_d = 1'b0;
      rel_d   = 1'b0;
      drv_d   = 1'b0;
      hold_d  = 6'h00;
    end else if (start_c) begin
      ev[`EV_START] = 1'b1;
      state_d  = ctrl_q.monitor ? ST_IDLE : ST_ADDR;
      bitcnt_d = 4'h0;
      stall_d  = 1'b0;
      drv_d    = 1'b0;
      hold_d   = 6'h00;
    end else if (stop_c) begin
      ev[`EV_STOP] = 1'b1;
      state_d = ST_IDLE;
      stall_d = 1'b0;
      drv_d   = 1'b0;
      hold_d  = 6'h00;
    end else begin
      case (state_q)
        ST_ADDR, ST_RX: begin
          if (scl.rise) begin
            shreg_d  = {shreg_q[6:0], sda.lvl};
            bitcnt_d = bitcnt_q + 4'h1;
          end else if (scl.fall && bitcnt_q == 4'h8) begin
            rxbyte_d = shreg_q;
            pend_d   = ~ctrl_q.nack;
            hold_d   = hold_sel;
            state_d  = ST_ACK;
            if (state_q == ST_ADDR) begin
              if (shreg_q[7:1] == own_q || ctrl_q.addr_all) begin
                ev[`EV_ADDR] = 1'b1;
                rw_d    = shreg_q[0];
                first_d = 1'b1;
                stall_d = !ctrl_q.buf_mode && !shreg_q[0];
              end else begin
                state_d = ST_IDLE;
                hold_d  = 6'h00;
              end
            end else begin
              ev[`EV_RX] = 1'b1;
              stall_d = !ctrl_q.buf_mode;
              if (ctrl_q.buf_mode && first_q) begin
                ptr_d   = shreg_q > 8'h1f ? 6'(`BUF_DEPTH) : shreg_q[5:0];
                first_d = 1'b0;
              end else if (ctrl_q.buf_mode && ptr_q < 6'(`BUF_DEPTH)) begin
                ram_we = 1'b1;
                ptr_d  = ptr_q + 6'h01;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl.fall) begin
            bitcnt_d = 4'h0;
            if (rw_q) begin
              state_d = ST_TX;
              go_tx   = 1'b1;
            end else begin
              state_d = ST_RX;
              pend_d  = 1'b0;
              hold_d  = hold_sel;
            end
          end
        end
        ST_TX: begin
          if (scl.rise) begin
            bitcnt_d = bitcnt_q + 4'h1;
          end else if (scl.fall) begin
            hold_d = hold_sel;
            if (bitcnt_q == 4'h8) begin
              state_d = ST_MACK;
              pend_d  = 1'b0;
            end else begin
              shreg_d = {shreg_q[6:0], 1'b0};
              pend_d  = ~shreg_q[6];
            end
          end
        end
        ST_MACK: begin
          if (scl.rise) begin
            mnack_d = sda.lvl;
          end else if (scl.fall) begin
            if (mnack_q) begin
              ev[`EV_NACK] = 1'b1;
              state_d = ST_IDLE;
            end else begin
              state_d  = ST_TX;
              bitcnt_d = 4'h0;
              go_tx    = 1'b1;
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
    if (go_tx) begin
      hold_d = hold_sel;
      if (ctrl_q.buf_mode) begin
        shreg_d = ram_rd;
        pend_d  = ~ram_rd[7];
        if (ptr_q < 6'(`BUF_DEPTH)) begin
          ptr_d = ptr_q + 6'h01;
        end
      end else begin
        ev[`EV_TX_REQ] = 1'b1;
        stall_d = 1'b1;
        pend_d  = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      state_q  <= ST_IDLE;
      shreg_q  <= 8'h00;
      rxbyte_q <= 8'h00;
      bitcnt_q <= 4'h0;
      ptr_q    <= 6'h00;
      rw_q     <= 1'b0;
      first_q  <= 1'b0;
      mnack_q  <= 1'b0;
      stall_q  <= 1'b0;
      rel_q    <= 1'b0;
      drv_q    <= 1'b0;
      pend_q   <= 1'b0;
      hold_q   <= 6'h00;
    end else begin
      state_q  <= state_d;
      shreg_q  <= shreg_d;
      rxbyte_q <= rxbyte_d;
      bitcnt_q <= bitcnt_d;
      ptr_q    <= ptr_d;
      rw_q     <= rw_d;
      first_q  <= first_d;
      mnack_q  <= mnack_d;
      stall_q  <= stall_d;
      rel_q    <= rel_d;
      drv_q    <= drv_d;
      pend_q   <= pend_d;
      hold_q   <= hold_d;
    end
  end

  // buffer storage, shared by bus writes and firmware
  always_ff @(posedge mclk_in) begin
    if (ram_we) begin
      ram[ptr_q[4:0]] <= shreg_q;
    end
    if (fw_ram_we) begin
      ram[fw_idx_q] <= reg_wdata_in;
    end
  end

  // register file
  always_comb begin
    ctrl_d   = ctrl_q;
    own_d    = own_q;
    mask_d   = mask_q;
    tx_d     = tx_q;
    fw_idx_d = fw_idx_q;
    status_d = status_q;
    rdata_d  = 8'h00;
    if (reg_wr_in) begin
      case (reg_addr_in)
        `REG_CTRL:      ctrl_d   = reg_wdata_in;
        `REG_OWN_ADDR:  own_d    = reg_wdata_in[6:0];
        `REG_STATUS:    status_d = status_q & ~reg_wdata_in[5:0];
        `REG_MASK:      mask_d   = reg_wdata_in[5:0];
        `REG_TX_DATA:   tx_d     = reg_wdata_in;
        `REG_BUF_INDEX: fw_idx_d = reg_wdata_in[4:0];
        default:        rdata_d  = 8'h00;
      endcase
    end
    status_d = status_d | ev;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `REG_CTRL:      rdata_d = ctrl_q;
        `REG_OWN_ADDR:  rdata_d = {1'b0, own_q};
        `REG_STATUS:    rdata_d = {2'h0, status_q};
        `REG_MASK:      rdata_d = {2'h0, mask_q};
        `REG_RX_DATA:   rdata_d = rxbyte_q;
        `REG_TX_DATA:   rdata_d = tx_q;
        `REG_BUS_STATE: rdata_d = {stall_q, rw_q, ptr_q};
        `REG_BUF_INDEX: rdata_d = {3'h0, fw_idx_q};
        `REG_BUF_DATA:  rdata_d = ram[fw_idx_q];
        default:        rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      ctrl_q   <= `CTRL_RESET;
      own_q    <= `ADDR_RESET;
      mask_q   <= 6'h00;
      tx_q     <= 8'h00;
      fw_idx_q <= 5'h00;
      status_q <= 6'h00;
      rdata_q  <= 8'h00;
    end else begin
      ctrl_q   <= ctrl_d;
      own_q    <= own_d;
      mask_q   <= mask_d;
      tx_q     <= tx_d;
      fw_idx_q <= fw_idx_d;
      status_q <= status_d;
      rdata_q  <= rdata_d;
    end
  end

  // pins are handed to general-purpose use while disabled
  assign reg_rdata_out = rdata_q;
  assign irq_out       = |(status_q & mask_q);
  assign scl_out_out   = 1'b0;
  assign sda_out_out   = 1'b0;
  assign scl_oe_out    = ctrl_q.enable ? stall_q : gpio_scl_low_in;
  assign sda_oe_out    = ctrl_q.enable ? drv_q : gpio_sda_low_in;

  chk_stall_buf_mode: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $rose(stall_q) |-> !ctrl_q.buf_mode) else $error("stall raised in buffer mode");
  chk_monitor_quiet: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    ctrl_q.enable && ctrl_q.monitor && $past(ctrl_q.monitor) && state_q == ST_IDLE
      |-> (state_q != ST_ADDR) [*2]) else $error("monitor mode left idle");
  chk_pins_gpio: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    !ctrl_q.enable |-> sda_oe_out == gpio_sda_low_in && scl_oe_out == gpio_scl_low_in)
    else $error("pins not handed to gpio");
  chk_addr_match: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state_q == ST_ADDR && scl.fall && bitcnt_q == 4'h8 && shreg_q[7:1] != own_q
      && !ctrl_q.addr_all && !start_c && !stop_c |=> state_q == ST_IDLE)
    else $error("foreign address accepted");
  chk_irq_follows: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $rose(status_q[`EV_RX]) && mask_q[`EV_RX] |-> irq_out) else $error("irq missing");
  chk_release_read: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    stall_q && !rw_q && fw_rx_rd && ctrl_q.enable && !start_c && !stop_c
      |-> ##[1:45] !stall_q) else $error("stall not released after read");
  chk_ptr_advance: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    ram_we && !start_c && !stop_c |=> ptr_q == $past(ptr_q) + 6'h01)
    else $error("buffer pointer did not advance");
  chk_first_loads: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    ctrl_q.enable && ctrl_q.buf_mode && state_q == ST_RX && scl.fall && bitcnt_q == 4'h8
      && first_q && shreg_q < 8'h20 && !start_c && !stop_c |=> ptr_q == $past(shreg_q[5:0]))
    else $error("first byte did not load pointer");
  chk_byte_whole: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $rose(status_q[`EV_RX]) |-> $past(bitcnt_q) == 4'h8) else $error("partial byte flagged");
endmodule
